// >>> add_and_instruction_datapath.sv
// Functional notes
// - add-literal adds the opcode low byte to the accumulator, result to accumulator
// - pattern 0010 01da decodes as accumulator plus addressed memory byte
// - pattern 0010 00da adds accumulator, memory byte and current carry
// - pattern 0000 1011 ANDs accumulator with literal into accumulator
// - pattern 0001 01da ANDs accumulator with addressed memory byte
// - destination bit 0 writes accumulator, 1 writes the memory byte
// - register destination overwrites the addressed memory byte with the result
// - access bit 0 uses access bank, 1 uses the bank select register
// - add-with-carry consumes carry then sets carry from the new sum
`timescale 1ns/10ps
`default_nettype none
module add_and_instruction_datapath
   import alu_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // instruction
   input  wire logic                   instrValid,
   input  wire logic [alu_pkg::OPC_W-1:0] opcode,
   output logic                        instrReady,
   output logic                        instrDone,
   output logic                        illegalOp,
   // bank select from the register file
   input  wire logic [alu_pkg::BANK_W-1:0] bank_select_reg,
   // data memory port
   output logic      [alu_pkg::ADDR_W-1:0] memAddr,
   output logic                        memRead,
   input  wire logic [alu_pkg::DATA_W-1:0] memRdata,
   output logic                        memWrite,
   output logic      [alu_pkg::DATA_W-1:0] memWdata,
   // architectural state
   output logic      [alu_pkg::DATA_W-1:0] working_accumulator,
   output logic                        carryFlag,
   output logic                        half_carry_flag,
   output logic                        zeroFlag,
   output logic                        signed_wrap_flag,
   output logic                        negativeFlag
);
   import alu_pkg::*;

   function automatic op_t decodeOp(input logic [OPC_W-1:0] w);
      op_t r;
      r = OP_NONE;
      // literal patterns first: their whole top byte is fixed
      if (w[15:8] == OPC_ADD_LIT) r = OP_ADD_LIT;
      else if (w[15:8] == OPC_AND_LIT) r = OP_AND_LIT;
      else if (w[15:10] == OPC_ADD_FILE) r = OP_ADD_FILE;
      else if (w[15:10] == OPC_ADC_FILE) r = OP_ADC_FILE;
      else if (w[15:10] == OPC_AND_FILE) r = OP_AND_FILE;
      return r;
   endfunction

   function automatic logic isFileOp(input op_t o);
      return (o == OP_ADD_FILE) || (o == OP_ADC_FILE) || (o == OP_AND_FILE);
   endfunction

   phase_t phase, next_phase;
   op_t op, next_op;
   logic [DATA_W-1:0] literal, next_literal;
   logic dest, next_dest;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [DATA_W-1:0] operand, next_operand;
   logic [DATA_W-1:0] result, next_result;
   logic [4:0] flags, next_flags;
   logic [DATA_W-1:0] next_acc;
   logic [DATA_W-1:0] next_memWdata;
   logic next_illegal;

   logic [DATA_W-1:0] addSum;
   logic addC;
   logic addHalf;
   logic addWrap;
   logic [DATA_W-1:0] andResult;
   logic useCarry;

   // carry enters only for add-with-carry
   assign useCarry = (op == OP_ADC_FILE) && flags[FLAG_C];

   // one shared adder serves all three add instructions
   alu_adder u_adder (
      .opA        (working_accumulator),
      .opB        (operand),
      .carryIn    (useCarry),
      .sum        (addSum),
      .carryOut   (addC),
      .halfCarry  (addHalf),
      .signedWrap (addWrap)
   );

   // strobes are combinational; address and write data come from registers
   assign instrReady = (phase == PH_DECODE);
   assign instrDone = (phase == PH_WRITE);
   assign memRead = (phase == PH_READ) && isFileOp(op);
   assign memWrite = (phase == PH_WRITE) && isFileOp(op) && dest;
   assign memAddr = addr;
   // flags live in one vector so an update is a single register write
   assign carryFlag = flags[FLAG_C];
   assign half_carry_flag = flags[FLAG_HALF];
   assign zeroFlag = flags[FLAG_Z];
   assign signed_wrap_flag = flags[FLAG_WRAP];
   assign negativeFlag = flags[FLAG_N];
   assign andResult = working_accumulator & operand;

   // sequencer: phase, decoded operation and operand address
   always_comb begin
      next_phase = phase;
      next_op = op;
      next_literal = literal;
      next_dest = dest;
      next_addr = addr;
      next_illegal = illegalOp;
      unique case (phase)
         PH_DECODE: begin
            // requests are only taken here, so no queue is needed
            if (instrValid) begin
               next_op = decodeOp(opcode);
               next_illegal = (decodeOp(opcode) == OP_NONE);
               next_literal = opcode[7:0];
               next_dest = opcode[DEST_BIT];
               // access bank: low half to bank 0, high half to top bank
               if (!opcode[ACCESS_BIT]) begin
                  next_addr = {(opcode[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                               : ACCESS_HIGH_BANK, opcode[7:0]};
               end else begin
                  next_addr = {bank_select_reg, opcode[7:0]};
               end
               next_phase = PH_READ;
            end
         end
         PH_READ: next_phase = PH_PROCESS;
         PH_PROCESS: next_phase = PH_WRITE;
         PH_WRITE: next_phase = PH_DECODE;
         default: next_phase = PH_DECODE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase <= PH_DECODE;
         op <= OP_NONE;
         literal <= ACC_RESET;
         dest <= 1'b0;
         addr <= '0;
         illegalOp <= 1'b0;
      end else begin
         phase <= next_phase;
         op <= next_op;
         literal <= next_literal;
         dest <= next_dest;
         addr <= next_addr;
         illegalOp <= next_illegal;
      end
   end

   // datapath: operand, result, flags and the two destinations
   always_comb begin
      next_operand = operand;
      next_result = result;
      next_flags = flags;
      next_acc = working_accumulator;
      next_memWdata = memWdata;
      unique case (phase)
         PH_DECODE: next_result = result;
         PH_READ: begin
            // literal ops take the immediate, file ops the memory byte
            next_operand = isFileOp(op) ? memRdata : literal;
         end
         PH_PROCESS: begin
            unique case (op)
               OP_ADD_LIT, OP_ADD_FILE, OP_ADC_FILE: begin
                  next_result = addSum;
                  next_flags[FLAG_C] = addC;
                  next_flags[FLAG_HALF] = addHalf;
                  next_flags[FLAG_WRAP] = addWrap;
                  next_flags[FLAG_Z] = (addSum == '0);
                  next_flags[FLAG_N] = addSum[DATA_W-1];
               end
               OP_AND_LIT, OP_AND_FILE: begin
                  next_result = andResult;
                  next_flags[FLAG_Z] = (andResult == '0);
                  next_flags[FLAG_N] = andResult[DATA_W-1];
               end
               // an unknown opcode leaves the result, the flags and the accumulator as they were
               OP_NONE: next_result = result;
               default: next_result = result;
            endcase
            // registered so the memory sees a settled byte in the write phase
            next_memWdata = next_result;
         end
         PH_WRITE: begin
            // literal ops always target the accumulator
            if (op != OP_NONE && (!isFileOp(op) || !dest)) begin
               next_acc = result;
            end
         end
         default: next_result = result;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         operand <= ACC_RESET;
         result <= ACC_RESET;
         flags <= FLAGS_RESET;
         working_accumulator <= ACC_RESET;
         memWdata <= ACC_RESET;
      end else begin
         operand <= next_operand;
         result <= next_result;
         flags <= next_flags;
         working_accumulator <= next_acc;
         memWdata <= next_memWdata;
      end
   end
endmodule
`default_nettype wire

// >>> alu_pkg.sv
package alu_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int BANK_W = 4;
   localparam int OPC_W = 16;
   // opcode patterns, upper bits compared
   localparam logic [7:0] OPC_ADD_LIT = 8'h0f;
   localparam logic [7:0] OPC_AND_LIT = 8'h0b;
   localparam logic [5:0] OPC_ADD_FILE = 6'h09;
   localparam logic [5:0] OPC_ADC_FILE = 6'h08;
   localparam logic [5:0] OPC_AND_FILE = 6'h05;
   // field positions
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   // access bank split: low half maps to bank 0, high half to bank 0xf
   localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h80;
   localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
   localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
   // reset values
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   // flag positions in the status vector
   localparam int FLAG_C = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_WRAP = 3;
   localparam int FLAG_N = 4;
   typedef enum logic [3:0] {
      PH_DECODE  = 4'b0001,
      PH_READ    = 4'b0010,
      PH_PROCESS = 4'b0100,
      PH_WRITE   = 4'b1000
   } phase_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_ADD_LIT, OP_AND_LIT, OP_ADD_FILE, OP_ADC_FILE, OP_AND_FILE
   } op_t;
endpackage

// >>> alu_adder.sv
`timescale 1ns/10ps
`default_nettype none
module alu_adder
   import alu_pkg::*;
(
   // operands
   input  wire logic [DATA_W-1:0] opA,
   input  wire logic [DATA_W-1:0] opB,
   input  wire logic              carryIn,
   // results
   output logic      [DATA_W-1:0] sum,
   output logic                   carryOut,
   output logic                   halfCarry,
   output logic                   signedWrap
);
   logic [4:0] lowSum;
   logic [4:0] highSum;
   always_comb begin
      lowSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
      highSum = {1'b0, opA[7:4]} + {1'b0, opB[7:4]} + {4'h0, lowSum[4]};
      sum = {highSum[3:0], lowSum[3:0]};
      carryOut = highSum[4];
      halfCarry = lowSum[4];
      signedWrap = (opA[7] == opB[7]) && (sum[7] != opA[7]);
   end
endmodule
`default_nettype wire

// >>> data_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
module data_memory_model
   import alu_pkg::*;
(
   // data memory port
   input  wire logic              clk,
   input  wire logic [ADDR_W-1:0] memAddr,
   input  wire logic              memRead,
   input  wire logic              memWrite,
   input  wire logic [DATA_W-1:0] memWdata,
   output logic      [DATA_W-1:0] memRdata
);
   logic [DATA_W-1:0] mem [2**ADDR_W];
   // inverted data outside a read, so a late sample never passes by luck
   assign memRdata = memRead ? mem[memAddr] : ~mem[memAddr];
   always @(posedge clk) begin
      if (memWrite) begin
         mem[memAddr] <= memWdata;
      end
   end
   initial begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
         // the bank term makes every bank differ, so a wrong bank reads a wrong byte
         mem[i] = DATA_W'(i * 37 + (i >> 8) * 91 + 5);
      end
   end
endmodule
`default_nettype wire

// >>> datapath_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module datapath_monitor
   import alu_pkg::*;
(
   input wire logic              clk, arst_n, instrValid, instrReady, instrDone, illegalOp,
   input wire logic [OPC_W-1:0]  opcode,
   input wire logic [BANK_W-1:0] bank_select_reg,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic              memRead, memWrite,
   input wire logic [DATA_W-1:0] memRdata, memWdata, working_accumulator,
   input wire logic              carryFlag, half_carry_flag, zeroFlag, signed_wrap_flag,
   input wire logic              negativeFlag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic take;
   logic fileOp;
   assign take = instrReady && instrValid;
   assign fileOp = opcode[15:10] inside {OPC_ADD_FILE, OPC_ADC_FILE, OPC_AND_FILE};
   a_four_phases: assert property (take |=> !instrReady [*3] ##1 instrReady)
      else $error("cycle length wrong");
   a_read_phase: assert property (take |=> memRead == $past(fileOp))
      else $error("read phase wrong");
   a_read_to_done: assert property (memRead |-> ##2 instrDone)
      else $error("done not two after read");
   a_done_pulse: assert property (instrDone |=> !instrDone && instrReady)
      else $error("done not one pulse");
   a_write_in_done: assert property (memWrite |-> instrDone)
      else $error("write outside write phase");
   a_banked_addr: assert property (take && fileOp && opcode[ACCESS_BIT] |=>
      memAddr == {$past(bank_select_reg), $past(opcode[7:0])})
      else $error("banked address wrong");
   a_access_addr: assert property (take && fileOp && !opcode[ACCESS_BIT] |=>
      memAddr == {($past(opcode[7:0]) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK,
      $past(opcode[7:0])})
      else $error("access bank address wrong");
   a_and_keeps_c: assert property (take && opcode[15:8] == OPC_AND_LIT |=>
      $stable(carryFlag) [*4])
      else $error("and changed carry");
   a_write_flags: assert property (memWrite |->
      zeroFlag == (memWdata == 8'h00) && negativeFlag == memWdata[7])
      else $error("flags disagree with written byte");
   a_acc_flags: assert property (instrDone && !memWrite && !illegalOp |=>
      zeroFlag == (working_accumulator == 8'h00))
      else $error("zero flag disagrees with accumulator");
   c_write: cover property (memWrite);
   c_illegal: cover property ($rose(illegalOp));
   c_carry_add: cover property (take && opcode[15:10] == OPC_ADC_FILE && carryFlag);
endmodule
bind add_and_instruction_datapath datapath_monitor mon (.clk, .arst_n, .instrValid,
   .instrReady, .instrDone, .illegalOp, .opcode, .bank_select_reg, .memAddr, .memRead,
   .memWrite, .memRdata, .memWdata, .working_accumulator, .carryFlag, .half_carry_flag,
   .zeroFlag, .signed_wrap_flag, .negativeFlag);
`default_nettype wire

// >>> add_and_instruction_datapath_bench.sv
`timescale 1ns/10ps
`default_nettype none
module add_and_instruction_datapath_bench;
   import alu_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, instrValid = 1'b0;
   logic [OPC_W-1:0] opcode = 16'h0000;
   logic [BANK_W-1:0] bank_select_reg = 4'h0;
   logic instrReady, instrDone, illegalOp, memRead, memWrite, carryFlag, half_carry_flag;
   logic zeroFlag, signed_wrap_flag, negativeFlag;
   logic [ADDR_W-1:0] memAddr;
   logic [DATA_W-1:0] memRdata, memWdata, working_accumulator, expAcc = 8'h00;
   logic [4:0] flags, expF = 5'h00;
   logic [15:0] rnd = 16'h8738;
   int err_count = 0, check_count = 0;
   localparam logic [15:0] CORNER [8] = '{16'h0f10, 16'h0f15, 16'h0b00, 16'h0f80,
      16'h0f80, 16'h2080, 16'h2281, 16'hffff};
   localparam logic [15:0] BASE [5] = '{16'h0f00, 16'h0b00, 16'h2400, 16'h2000, 16'h1400};
   assign flags = {negativeFlag, signed_wrap_flag, zeroFlag, half_carry_flag, carryFlag};
   always #50 clk = ~clk;
   add_and_instruction_datapath uut (.clk, .arst_n, .instrValid, .opcode, .instrReady,
      .instrDone, .illegalOp, .bank_select_reg, .memAddr, .memRead, .memRdata, .memWrite,
      .memWdata, .working_accumulator, .carryFlag, .half_carry_flag, .zeroFlag,
      .signed_wrap_flag, .negativeFlag);
   data_memory_model pm (.clk, .memAddr, .memRead, .memWrite, .memWdata, .memRdata);
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [12:0] alu(input logic [15:0] op, input logic [7:0] m);
      logic [7:0] k;
      logic [8:0] s;
      logic [4:0] h;
      logic [4:0] f;
      logic c;
      f = expF;
      k = (op[15:12] == 4'h0) ? op[7:0] : m;
      c = (op[15:10] == OPC_ADC_FILE) ? expF[FLAG_C] : 1'b0;
      s = expAcc + k + c;
      h = expAcc[3:0] + k[3:0] + c;
      if (op[15:8] == OPC_AND_LIT || op[15:10] == OPC_AND_FILE) begin
         s = {1'b0, expAcc & k};
      end else begin
         f[FLAG_C] = s[8];
         f[FLAG_HALF] = h[4];
         f[FLAG_WRAP] = (expAcc[7] == k[7]) && (s[7] != expAcc[7]);
      end
      f[FLAG_Z] = (s[7:0] == 8'h00);
      f[FLAG_N] = s[7];
      return {f, s[7:0]};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic issue(input logic [15:0] op);
      logic [11:0] a;
      logic [12:0] r;
      logic [3:0] nb;
      logic ok;
      int n;
      rnd = lfsr(rnd);
      nb = rnd[3:0];
      a = {op[ACCESS_BIT] ? nb : (op[7:0] < ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK),
         op[7:0]};
      ok = op[15:8] inside {OPC_ADD_LIT, OPC_AND_LIT} || op[15:10] inside {OPC_ADD_FILE,
         OPC_ADC_FILE, OPC_AND_FILE};
      r = alu(op, pm.mem[a]);
      for (n = 0; n < 8 && instrReady !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      // a hung sequencer counts once per request; the run still ends at the report
      if (n == 8) begin
         err_count++;
         $display("BAD instrReady expected 1 seen %b", instrReady);
         return;
      end
      @(posedge clk);
      instrValid <= 1'b1;
      opcode <= op;
      bank_select_reg <= nb;
      @(posedge clk);
      instrValid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      if (ok && (op[15:12] == 4'h0 || !op[DEST_BIT])) begin
         expAcc = r[7:0];
      end else if (ok) begin
         chk("memory", r[7:0], pm.mem[a]);
      end
      if (ok) begin
         expF = r[12:8];
      end
      chk("accumulator", expAcc, working_accumulator);
      chk("flags", {3'h0, expF}, {3'h0, flags});
      chk("illegal", {7'h0, !ok}, {7'h0, illegalOp});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk("reset accumulator", ACC_RESET, working_accumulator);
      chk("reset flags", {3'h0, FLAGS_RESET}, {3'h0, flags});
      foreach (CORNER[i]) issue(CORNER[i]);
      // mid-run reset must clear what the corner cases left behind
      @(posedge clk);
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      #1;
      expAcc = ACC_RESET;
      expF = FLAGS_RESET;
      chk("mid reset accumulator", ACC_RESET, working_accumulator);
      chk("mid reset flags", {3'h0, FLAGS_RESET}, {3'h0, flags});
      for (int i = 0; i < 120; i++) begin
         rnd = lfsr(rnd);
         issue(BASE[rnd % 5] | {6'h00, rnd[9:0] & ((rnd % 5 < 2) ? 10'h0ff : 10'h3ff)});
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
